// ---- verilog/selftest_pkg.sv ----
/*
 * Shared constants and carrier types for the reference monitor and
 * comparator self-test block. Assumes a 100 MHz system clock.
 */
`default_nettype none
package selftest_pkg;

    // Register byte offsets on the Avalon-MM slave.
    localparam logic [4:0] OFS_CONTROL    = 5'h00;
    localparam logic [4:0] OFS_STATUS     = 5'h04;
    localparam logic [4:0] OFS_UNLOCK     = 5'h08;
    localparam logic [4:0] OFS_SW_OV      = 5'h0C;
    localparam logic [4:0] OFS_LDO_OV     = 5'h10;
    localparam logic [4:0] OFS_SW_UV      = 5'h14;
    localparam logic [4:0] OFS_LDO_UV     = 5'h18;

    // Control register bit positions.
    localparam int CTL_RUN     = 0;
    localparam int CTL_BYPASS  = 1;
    localparam int CTL_SECURE  = 2;
    localparam int CTL_REFMASK = 3;

    // Status register bit positions.
    localparam int STS_REF_NOW  = 0;
    localparam int STS_REF_FLAG = 1;
    localparam int STS_ON       = 2;
    localparam int STS_BLOCKED  = 3;
    localparam int STS_SHUTDOWN = 4;

    // Unlock value for the secure write sequence; the value is arbitrary.
    localparam logic [7:0] UNLOCK_KEY = 8'hA5;

    // Regulator counts and the flat comparator layout.
    localparam int NUM_SW  = 7;
    localparam int NUM_LDO = 4;
    localparam int NUM_CMP = 2 * (NUM_SW + NUM_LDO);
    localparam logic [4:0] LAST_CMP = 5'(NUM_CMP - 1);

    // Reset values.
    localparam logic [7:0] CONTROL_RESET = 8'h00;

    // Timing: each comparator phase lasts one step.
    localparam int CLK_PERIOD_NS  = 10;
    localparam int STEP_TIME_NS   = 4000;
    localparam int STEP_CYCLES    = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BLANK_MAX_US   = 200;
    localparam logic [8:0] STEP_LAST = 9'(STEP_CYCLES - 1);

    typedef enum logic [2:0] {
        ST_REFCHK  = 3'h0,
        ST_FORCE   = 3'h1,
        ST_RELEASE = 3'h3,
        ST_ON      = 3'h2,
        ST_BLOCKED = 3'h6
    } phase_t;

    typedef struct packed {
        logic [4:0]  address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } avs_req_t;

    typedef struct packed {
        logic [NUM_LDO-1:0] ldo_uv;
        logic [NUM_SW-1:0]  sw_uv;
        logic [NUM_LDO-1:0] ldo_ov;
        logic [NUM_SW-1:0]  sw_ov;
    } cmp_vec_t;

endpackage
`default_nettype wire

// ---- verilog/monitor_selftest.sv ----
/*
 * Reference monitor and analog comparator self-test controller with an
 * Avalon-MM register slave.
 * Assumes the comparator and mismatch inputs are synchronous to clk_in and
 * that the analog front end reacts to a force within one step.
 */
// Operation
// - Power-up reference mismatch is critical; regulators stay off.
// - Power-up mismatch fails test, ignores bypass.
// - Runtime drift, bypass 0: shut power stages.
// - Runtime drift, bypass 1: interrupt only.
// - Reference flag sets even when masked; mask gates only the interrupt.
// - Status bit follows current reference condition.
// - Test every overvoltage comparator individually.
// - Test every undervoltage comparator individually.
// - Untoggled comparator sets its warning bit.
// - Warnings in four per-regulator groups.
// - Each run overwrites all warning bits.
// - In secure mode, warnings clear only by secure write.
// - After power-up test, continue; results readable.
// - Writing run bit starts full test.
// - Run bit self-clears; new request accepted.
// - Secure mode: start needs secure write.
// - Blanking during on-demand test under 200 us.
// - On-demand failure sets that monitor's flags.
`timescale 1ns/1ns
`default_nettype none
module monitor_selftest (
    input  wire logic                     clk_in,
    input  wire logic                     reset_n_in,
    input  wire selftest_pkg::avs_req_t   avs_req_in,
    output logic [31:0]                   avs_readdata_out,
    output logic                          avs_waitrequest_out,
    input  wire logic                     ref_mismatch_in,
    input  wire selftest_pkg::cmp_vec_t   cmp_state_in,
    output selftest_pkg::cmp_vec_t        cmp_force_out,
    output logic                          monitor_blank_out,
    output logic                          regulator_enable_out,
    output logic                          power_stage_shutdown_out,
    output logic                          reference_fail_irq_out
);

    // Overview of behaviour, for whoever integrates or extends this block.
    //
    // The block sits between the analog monitoring front end and the host
    // register interface. It owns three jobs: checking that the regulation
    // reference and the monitoring reference agree, stepping through every
    // overvoltage and undervoltage comparator to prove that each can toggle,
    // and presenting the results as registers on the Avalon-MM slave.
    //
    // Reference check.
    // The mismatch input is the result of an analog window comparison. It is
    // high while the two references differ by more than the allowed band.
    // Right after reset the sequencer looks at it once, in the first phase.
    // A mismatch there parks the sequencer in the blocked phase for good, so
    // the regulators are never enabled until the next reset. The bypass
    // setting is deliberately ignored at that point, because a bad reference
    // at power-up means neither regulation nor monitoring can be trusted.
    // Once the system is on, a mismatch either shuts the power stages down
    // (bypass clear) or only raises the interrupt flag (bypass set).
    // The shutdown is sticky until reset. Clearing it by software would let a
    // drifting reference restart the regulators without any fresh check.
    //
    // Interrupt flag.
    // The reference flag sets on every cycle that sees a mismatch, in any
    // phase. Software clears it by writing a one to its status bit. When a
    // clear and a new mismatch fall in the same cycle the flag stays set, so
    // an event can never be lost in the gap between a read and a clear.
    // The interrupt output is the flag gated by its mask bit. Masking hides
    // the event from the interrupt line but the flag itself still records it.
    //
    // Comparator self-test.
    // There are twenty-two comparators: overvoltage for each of seven
    // switchers, overvoltage for each of four linear regulators, then the
    // same two groups for undervoltage. They are tested one at a time, in
    // that flat order, which is also the bit order of the warning registers.
    // Each comparator gets a force step followed by a release step. At the
    // end of the force step its output must read tripped, and at the end of
    // the release step it must read idle. Missing either edge marks it failed.
    // Checking only at the end of each step gives the analog side a full step
    // to settle, at the price of not catching a comparator that chatters.
    // Forcing a single comparator at a time keeps one broken channel from
    // masking another, and lets the warning bit point at the exact monitor.
    //
    // Timing.
    // A step lasts four microseconds, so a full pass costs 22 x 2 steps, or
    // 176 microseconds. Fault monitoring is blanked for the whole pass, which
    // keeps the blanking window inside its 200 microsecond budget with some
    // margin for clock tolerance. The step length is a package constant; a
    // longer step would need the timer widened and the budget rechecked.
    //
    // Power-up and on-demand runs.
    // A power-up run starts by itself when the reference check passes. Its
    // failures are reported but do not stop the power-up; the host is
    // expected to read the warning registers and act on them. An on-demand
    // run starts from a write of one to the run bit, but only in the on phase
    // and only while no shutdown is latched. A write during a run is ignored,
    // so a nervous host cannot stretch the blanking window by repeating it.
    // The run bit reads one while an on-demand run is in progress and drops
    // back to zero by itself when the last comparator has been checked.
    // Every run clears all warning bits at its start, so old results never
    // mix with new ones.
    //
    // Register access and protection.
    // The slave answers every access after exactly one wait cycle. Read data
    // is registered at the end of the first cycle and stands until the next
    // read. Only the low byte lane carries meaning; upper bits read as zero.
    // When secure mode is on, a protected write needs the unlock key written
    // just before it. The key arms exactly one write, whatever its target,
    // which keeps a stale key from unlocking a later unrelated access.
    // Protected writes are the warning clears, starting a run and leaving
    // secure mode. A refused write completes normally on the bus and simply
    // has no effect, so the host must read back to confirm.
    //
    // Hazards.
    // The mismatch and comparator inputs are taken as synchronous. If the
    // analog side is asynchronous to this clock, synchronisers belong in
    // front of this block, and the step length must cover their latency.
    // A failure found by the sequencer wins over a software clear landing in
    // the same cycle, for the same reason as the reference flag.
    //

    // Whole module state in one record.
    typedef struct packed {
        selftest_pkg::phase_t  phase;
        logic [4:0]            index;
        logic [8:0]            timer;
        logic                  demand;
        logic                  ack;
        logic [31:0]           rdata;
        logic                  bypass;
        logic                  secure;
        logic                  ref_mask;
        logic                  unlocked;
        logic                  ref_flag;
        logic                  blocked;
        logic                  shutdown;
        logic [selftest_pkg::NUM_CMP-1:0] fail;
    } state_t;

    state_t st;
    state_t next_st;

    logic [selftest_pkg::NUM_CMP-1:0] cmp_flat;
    logic [selftest_pkg::NUM_CMP-1:0] force_flat;
    logic                             testing;

    assign cmp_flat = cmp_state_in;
    assign testing  = (st.phase == selftest_pkg::ST_FORCE) ||
                      (st.phase == selftest_pkg::ST_RELEASE);

    // One-hot force: only the comparator under test sees a stimulus.
    genvar g;
    generate
        for (g = 0; g < selftest_pkg::NUM_CMP; g++) begin : gen_force
            assign force_flat[g] = (st.phase == selftest_pkg::ST_FORCE) &&
                                   (st.index == 5'(g));
        end
    endgenerate

    // Outputs; handshake is combinational, data comes from flip-flops.
    assign cmp_force_out            = force_flat;
    assign monitor_blank_out        = testing;
    assign regulator_enable_out     = (st.phase == selftest_pkg::ST_ON) &&
                                      !st.shutdown;
    assign power_stage_shutdown_out = st.shutdown;
    assign reference_fail_irq_out   = st.ref_flag && !st.ref_mask;
    assign avs_readdata_out         = st.rdata;
    assign avs_waitrequest_out      = (avs_req_in.read || avs_req_in.write) && !st.ack;

    // Next-state logic for bus, sequencer and reference monitor.
    always_comb begin
        logic        req;
        logic        wr_fire;
        logic        allowed;
        logic        wlane;
        logic [7:0]  wbyte;
        logic [31:0] rd;
        logic        step_done;
        logic        bit_fail;
        logic        start_req;
        logic        clr_ref;
        logic [selftest_pkg::NUM_CMP-1:0] clr_mask;

        next_st   = st;
        req       = avs_req_in.read || avs_req_in.write;
        wr_fire   = avs_req_in.write && st.ack;
        wlane     = avs_req_in.byteenable[0];
        wbyte     = avs_req_in.writedata[7:0];
        // Protected writes pass when secure mode is off or a key was given.
        allowed   = !st.secure || st.unlocked;
        rd        = 32'h0000_0000;
        step_done = (st.timer == selftest_pkg::STEP_LAST);
        bit_fail  = 1'b0;
        start_req = 1'b0;
        clr_ref   = 1'b0;
        clr_mask  = '0;

        // Answer one cycle after the request is seen; data is latched then.
        next_st.ack = req && !st.ack;
        if (req && !st.ack && avs_req_in.read) begin
            unique case (avs_req_in.address)
                selftest_pkg::OFS_CONTROL: begin
                    rd[selftest_pkg::CTL_RUN]     = st.demand && testing;
                    rd[selftest_pkg::CTL_BYPASS]  = st.bypass;
                    rd[selftest_pkg::CTL_SECURE]  = st.secure;
                    rd[selftest_pkg::CTL_REFMASK] = st.ref_mask;
                end
                selftest_pkg::OFS_STATUS: begin
                    rd[selftest_pkg::STS_REF_NOW]  = ref_mismatch_in;
                    rd[selftest_pkg::STS_REF_FLAG] = st.ref_flag;
                    rd[selftest_pkg::STS_ON]       = st.phase == selftest_pkg::ST_ON;
                    rd[selftest_pkg::STS_BLOCKED]  = st.blocked;
                    rd[selftest_pkg::STS_SHUTDOWN] = st.shutdown;
                end
                selftest_pkg::OFS_UNLOCK: rd[0] = st.unlocked;
                selftest_pkg::OFS_SW_OV:
                    rd[selftest_pkg::NUM_SW-1:0] = st.fail[6:0];
                selftest_pkg::OFS_LDO_OV:
                    rd[selftest_pkg::NUM_LDO-1:0] = st.fail[10:7];
                selftest_pkg::OFS_SW_UV:
                    rd[selftest_pkg::NUM_SW-1:0] = st.fail[17:11];
                selftest_pkg::OFS_LDO_UV:
                    rd[selftest_pkg::NUM_LDO-1:0] = st.fail[21:18];
                default: rd = 32'h0000_0000;
            endcase
            next_st.rdata = rd;
        end

        // Register writes commit on the edge where waitrequest is low.
        if (wr_fire && wlane) begin
            unique case (avs_req_in.address)
                selftest_pkg::OFS_CONTROL: begin
                    next_st.bypass   = wbyte[selftest_pkg::CTL_BYPASS];
                    next_st.ref_mask = wbyte[selftest_pkg::CTL_REFMASK];
                    // Leaving secure mode itself needs the key, so a stray
                    // write cannot drop the protection.
                    if (allowed) begin
                        next_st.secure = wbyte[selftest_pkg::CTL_SECURE];
                    end
                    start_req = wbyte[selftest_pkg::CTL_RUN] && allowed;
                end
                selftest_pkg::OFS_STATUS:
                    clr_ref = wbyte[selftest_pkg::STS_REF_FLAG];
                selftest_pkg::OFS_SW_OV:
                    if (allowed) clr_mask[6:0] = wbyte[6:0];
                selftest_pkg::OFS_LDO_OV:
                    if (allowed) clr_mask[10:7] = wbyte[3:0];
                selftest_pkg::OFS_SW_UV:
                    if (allowed) clr_mask[17:11] = wbyte[6:0];
                selftest_pkg::OFS_LDO_UV:
                    if (allowed) clr_mask[21:18] = wbyte[3:0];
                default: ;
            endcase
        end

        // The key arms exactly one following write, then lapses.
        if (wr_fire) begin
            next_st.unlocked = (avs_req_in.address == selftest_pkg::OFS_UNLOCK) &&
                               wlane && (wbyte == selftest_pkg::UNLOCK_KEY);
        end

        // Warning clears by software; a failure found later wins.
        next_st.fail = st.fail & ~clr_mask;

        // Comparator sequencer.
        unique case (st.phase)
            selftest_pkg::ST_REFCHK: begin
                // Power-up mismatch blocks regardless of bypass.
                if (ref_mismatch_in) begin
                    next_st.phase   = selftest_pkg::ST_BLOCKED;
                    next_st.blocked = 1'b1;
                end else begin
                    next_st.phase = selftest_pkg::ST_FORCE;
                    next_st.index = 5'h00;
                    next_st.timer = 9'h000;
                    next_st.fail  = '0;
                end
            end
            selftest_pkg::ST_FORCE: begin
                next_st.timer = st.timer + 9'h001;
                if (step_done) begin
                    // A forced comparator must report the fault.
                    bit_fail      = !cmp_flat[st.index];
                    next_st.timer = 9'h000;
                    next_st.phase = selftest_pkg::ST_RELEASE;
                end
            end
            selftest_pkg::ST_RELEASE: begin
                next_st.timer = st.timer + 9'h001;
                if (step_done) begin
                    // And must fall back once released, proving a toggle.
                    bit_fail      = cmp_flat[st.index];
                    next_st.timer = 9'h000;
                    if (st.index == selftest_pkg::LAST_CMP) begin
                        next_st.phase  = selftest_pkg::ST_ON;
                        next_st.demand = 1'b0;
                    end else begin
                        next_st.index = st.index + 5'h01;
                        next_st.phase = selftest_pkg::ST_FORCE;
                    end
                end
            end
            selftest_pkg::ST_ON: begin
                // A request while a run is busy cannot land here.
                if (start_req && !st.shutdown) begin
                    next_st.phase  = selftest_pkg::ST_FORCE;
                    next_st.demand = 1'b1;
                    next_st.index  = 5'h00;
                    next_st.timer  = 9'h000;
                    next_st.fail   = '0;
                end
            end
            selftest_pkg::ST_BLOCKED: ;
            default: next_st.phase = selftest_pkg::ST_BLOCKED;
        endcase

        if (bit_fail) begin
            next_st.fail[st.index] = 1'b1;
        end

        // Runtime drift while the system is on.
        if (st.phase == selftest_pkg::ST_ON && ref_mismatch_in && !st.bypass) begin
            next_st.shutdown = 1'b1;
        end

        // Sticky reference flag; an event in the clear cycle survives.
        if (clr_ref) begin
            next_st.ref_flag = 1'b0;
        end
        if (ref_mismatch_in) begin
            next_st.ref_flag = 1'b1;
        end
    end

    // The only clocked process; reset values are all constants.
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            st          <= '0;
            st.phase    <= selftest_pkg::ST_REFCHK;
            st.bypass   <= selftest_pkg::CONTROL_RESET[selftest_pkg::CTL_BYPASS];
            st.secure   <= selftest_pkg::CONTROL_RESET[selftest_pkg::CTL_SECURE];
            st.ref_mask <= selftest_pkg::CONTROL_RESET[selftest_pkg::CTL_REFMASK];
        end else begin
            st <= next_st;
        end
    end

endmodule
`default_nettype wire

// ---- dv/monitor_selftest_checker.sv ----
/* Port-level assertions for the reference monitor and comparator self-test.
   Assumes it is bound to monitor_selftest and reset is active low. */
`timescale 1ns/1ns
`default_nettype none
module monitor_selftest_checker (
    input wire logic                   clk_in,
    input wire logic                   reset_n_in,
    input wire selftest_pkg::avs_req_t avs_req_in,
    input wire logic [31:0]            avs_readdata_out,
    input wire logic                   avs_waitrequest_out,
    input wire logic                   ref_mismatch_in,
    input wire selftest_pkg::cmp_vec_t cmp_force_out,
    input wire logic                   monitor_blank_out,
    input wire logic                   regulator_enable_out,
    input wire logic                   power_stage_shutdown_out,
    input wire logic                   reference_fail_irq_out
);
    logic [21:0] last_f;
    logic [15:0] step_n;
    logic [15:0] blank_n;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    // Counters replace long repetitions, which the tools would unroll.
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            last_f <= '0;
            step_n <= '0;
            blank_n <= '0;
        end else begin
            last_f <= (cmp_force_out != 0) ? cmp_force_out : last_f;
            step_n <= (cmp_force_out != 0) ? step_n + 16'h1 : 16'h0;
            blank_n <= monitor_blank_out ? blank_n + 16'h1 : 16'h0;
        end
    end
    a_wait_one: assert property ((avs_req_in.read || avs_req_in.write) && avs_waitrequest_out
        |=> !avs_waitrequest_out) else $error("waitrequest held too long");
    a_status_live: assert property (avs_req_in.read && avs_waitrequest_out &&
        avs_req_in.address == selftest_pkg::OFS_STATUS |=> avs_readdata_out[0] ==
        $past(ref_mismatch_in)) else $error("live reference bit wrong");
    a_shut_cause: assert property ($rose(power_stage_shutdown_out) |->
        $past(ref_mismatch_in) && $past(regulator_enable_out)) else $error("bad shutdown");
    a_shut_hold: assert property (power_stage_shutdown_out |->
        !regulator_enable_out ##1 power_stage_shutdown_out) else $error("shutdown not held");
    a_irq_cause: assert property ($rose(reference_fail_irq_out) |->
        $past(ref_mismatch_in) || $past(avs_req_in.write)) else $error("spurious irq");
    a_blank_max: assert property (monitor_blank_out |-> blank_n < 16'd20000)
        else $error("blanking too long");
    a_force_blank: assert property (cmp_force_out != 0 |-> monitor_blank_out)
        else $error("force outside blanking");
    a_force_one: assert property ($onehot0(cmp_force_out))
        else $error("more than one comparator forced");
    a_force_order: assert property (cmp_force_out != 0 && $past(cmp_force_out) == 0 |->
        cmp_force_out == ((last_f == 0 || last_f[21]) ? 22'h1 : (last_f << 1)))
        else $error("comparator skipped");
    a_force_len: assert property ($past(cmp_force_out) != 0 && cmp_force_out == 0 |->
        step_n == selftest_pkg::STEP_CYCLES) else $error("force step length wrong");
endmodule
bind monitor_selftest monitor_selftest_checker u_monitor_selftest_checker (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .avs_req_in(avs_req_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .ref_mismatch_in(ref_mismatch_in), .cmp_force_out(cmp_force_out),
    .monitor_blank_out(monitor_blank_out), .regulator_enable_out(regulator_enable_out),
    .power_stage_shutdown_out(power_stage_shutdown_out),
    .reference_fail_irq_out(reference_fail_irq_out));
`default_nettype wire

// ---- dv/cmp_front_end.sv ----
/* Behavioural model of the analog comparators under self-test.
   Assumes force and stuck masks share the package comparator layout. */
`timescale 1ns/1ns
`default_nettype none
module cmp_front_end (
    input  wire logic             clk_in,
    input  wire selftest_pkg::cmp_vec_t force_in,
    input  wire selftest_pkg::cmp_vec_t stuck_in,
    output selftest_pkg::cmp_vec_t      state_out
);
    // A forced comparator trips one cycle later; a stuck one never toggles.
    always_ff @(posedge clk_in) begin
        state_out <= force_in & ~stuck_in;
    end
endmodule
`default_nettype wire

// ---- dv/monitor_selftest_tb_top.sv ----
/* Self-checking bench: Avalon register tasks, comparator model, checker.
   Assumes a 100 MHz clock and the package register map. */
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin error_cnt++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module monitor_selftest_tb_top;
    logic                   clk_in = 1'b0;
    logic                   reset_n_in = 1'b0;
    selftest_pkg::avs_req_t req = 43'h00F;
    logic [31:0]            readdata;
    logic                   wait_r;
    logic                   mism = 1'b0;
    selftest_pkg::cmp_vec_t state;
    selftest_pkg::cmp_vec_t force_v;
    selftest_pkg::cmp_vec_t stuck = 22'h220084;
    logic                   blank;
    logic                   reg_en;
    logic                   shut;
    logic                   irq;
    logic [31:0]            rdat;
    logic [31:0]            exp_a [4] = '{32'h04, 32'h01, 32'h40, 32'h08};
    int                     error_cnt = 0;
    int                     samples_checked = 0;
    int                     cyc = 0;
    int                     n;
    // Free-running system clock.
    initial begin
        forever #5 clk_in = ~clk_in;
    end
    monitor_selftest u_monitor_selftest (
        .clk_in(clk_in), .reset_n_in(reset_n_in), .avs_req_in(req),
        .avs_readdata_out(readdata), .avs_waitrequest_out(wait_r),
        .ref_mismatch_in(mism), .cmp_state_in(state), .cmp_force_out(force_v),
        .monitor_blank_out(blank), .regulator_enable_out(reg_en),
        .power_stage_shutdown_out(shut), .reference_fail_irq_out(irq));
    cmp_front_end u_cmp_front_end (
        .clk_in(clk_in), .force_in(force_v), .stuck_in(stuck), .state_out(state));
    // One Avalon access; held until waitrequest is sampled low.
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk_in);
        req.address <= a;
        req.read <= ~wr;
        req.write <= wr;
        req.writedata <= d;
        // Look at waitrequest mid-cycle where it is settled, then act on the edge.
        @(negedge clk_in);
        while (wait_r !== 1'b0) @(negedge clk_in);
        @(posedge clk_in);
        rdat = readdata;
        req.read <= 1'b0;
        req.write <= 1'b0;
    endtask
    task automatic sec_wr(input logic [4:0] a, input logic [31:0] d);
        bus(1'b1, selftest_pkg::OFS_UNLOCK, {24'h0, selftest_pkg::UNLOCK_KEY});
        bus(1'b1, a, d);
    endtask
    task automatic rc(input logic [4:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK(rdat, e)
    endtask
    // Bounded wait for the blanking window of a self-test to end.
    task automatic wait_idle;
        n = 0;
        @(negedge clk_in);
        while (blank !== 1'b0 && n < 25000) begin
            @(negedge clk_in);
            n++;
        end
        @(posedge clk_in);
    endtask
    task automatic close_out;
        $display("mismatches=%0d comparisons=%0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Three full self-test runs take about 53000 cycles, so this leaves margin.
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            error_cnt++;
            close_out();
        end
    end
    // Main sequence; one stuck comparator per group: index 2 of switcher overvoltage, first of LDO overvoltage, last of both undervoltage groups.
    initial begin
        repeat (8) @(posedge clk_in);
        reset_n_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        `CHK(blank, 1'b1)
        wait_idle();
        `CHK(reg_en, 1'b1)
        for (int i = 0; i < 4; i++) rc(selftest_pkg::OFS_SW_OV + 5'(4 * i), exp_a[i]);
        rc(5'h1C, 32'h0);
        stuck <= 22'h2;
        bus(1'b1, selftest_pkg::OFS_CONTROL, 32'h1);
        rc(selftest_pkg::OFS_CONTROL, 32'h1);
        `CHK(blank, 1'b1)
        repeat (9000) @(posedge clk_in);
        bus(1'b1, selftest_pkg::OFS_CONTROL, 32'h1);
        wait_idle();
        rc(selftest_pkg::OFS_CONTROL, 32'h0);
        rc(selftest_pkg::OFS_SW_OV, 32'h2);
        rc(selftest_pkg::OFS_LDO_UV, 32'h0);
        bus(1'b1, selftest_pkg::OFS_CONTROL, 32'h4);
        bus(1'b1, selftest_pkg::OFS_SW_OV, 32'h2);
        rc(selftest_pkg::OFS_SW_OV, 32'h2);
        sec_wr(selftest_pkg::OFS_SW_OV, 32'h2);
        rc(selftest_pkg::OFS_SW_OV, 32'h0);
        bus(1'b1, selftest_pkg::OFS_CONTROL, 32'h5);
        rc(selftest_pkg::OFS_CONTROL, 32'h4);
        stuck <= 22'h0;
        sec_wr(selftest_pkg::OFS_CONTROL, 32'h5);
        rc(selftest_pkg::OFS_CONTROL, 32'h5);
        wait_idle();
        sec_wr(selftest_pkg::OFS_CONTROL, 32'h6);
        mism <= 1'b1;
        repeat (4) @(posedge clk_in);
        `CHK({irq, reg_en, shut}, 3'b110)
        rc(selftest_pkg::OFS_STATUS, 32'h7);
        sec_wr(selftest_pkg::OFS_CONTROL, 32'hE);
        mism <= 1'b0;
        @(posedge clk_in);
        `CHK(irq, 1'b0)
        rc(selftest_pkg::OFS_STATUS, 32'h6);
        sec_wr(selftest_pkg::OFS_CONTROL, 32'h4);
        mism <= 1'b1;
        repeat (4) @(posedge clk_in);
        `CHK({shut, reg_en}, 2'b10)
        reset_n_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        reset_n_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        `CHK({reg_en, blank}, 2'b00)
        rc(selftest_pkg::OFS_STATUS, 32'hB);
        mism <= 1'b0;
        repeat (4) @(posedge clk_in);
        `CHK(reg_en, 1'b0)
        close_out();
    end
endmodule
`default_nettype wire
